// ==== dv/isb_front_end_checker.sv ====
/*
 concurrent checks on the i2c slave buffer front end ports.
 assumes one core clock domain with synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module isb_front_end_checker (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       scl_oe,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       chip_select_0_or_io_n,
	input wire logic       chip_select_1_or_io_n,
	input wire logic       chip_select_2_or_io_n,
	input wire logic       chip_select_3_or_io_n,
	input wire logic [3:0] io_select,
	input wire logic [3:0] io_level,
	input wire logic       irq_clear,
	input wire logic       irq_n,
	input wire logic       busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	wire [3:0] sel_n = {chip_select_3_or_io_n, chip_select_2_or_io_n,
		chip_select_1_or_io_n, chip_select_0_or_io_n};

	a_never_drive_high: assert property (!scl_out && !sda_out)
		else $error("bus line driven high");
	a_sda_on_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("sda drive changed while scl high");
	a_stretch_on_low: assert property ($rose(scl_oe) |-> !scl_in && !$past(scl_in))
		else $error("stretch began while scl high");
	a_stretch_one: assert property (scl_oe |=> !scl_oe)
		else $error("stretch longer than one cycle");
	a_busy_no_ack: assert property (busy |-> !sda_oe)
		else $error("sda driven while function runs");
	a_irq_at_done: assert property ($fell(irq_n) |-> $fell(busy))
		else $error("interrupt without finished transfer");
	a_irq_clear: assert property (irq_clear && !busy |=> irq_n)
		else $error("interrupt not cleared");
	property p_sel_idle;
		!busy && io_select == 4'h0 && $past(io_select) == 4'h0 |-> sel_n == 4'hf;
	endproperty
	property p_pin_follow;
		io_select[0] && $past(io_select[0]) |-> chip_select_0_or_io_n == $past(io_level[0]);
	endproperty
	a_sel_idle: assert property (p_sel_idle)
		else $error("chip select low while idle");
	a_pin_follow: assert property (p_pin_follow)
		else $error("general pin does not follow level");

	c_done: cover property ($fell(busy));
	c_drive: cover property ($rose(sda_oe));
	c_stretch: cover property ($rose(scl_oe));
endmodule

bind isb_front_end isb_front_end_checker u_chk (
	.core_clk              (core_clk),
	.sys_rst               (sys_rst),
	.scl_in                (scl_in),
	.scl_out               (scl_out),
	.scl_oe                (scl_oe),
	.sda_out               (sda_out),
	.sda_oe                (sda_oe),
	.chip_select_0_or_io_n (chip_select_0_or_io_n),
	.chip_select_1_or_io_n (chip_select_1_or_io_n),
	.chip_select_2_or_io_n (chip_select_2_or_io_n),
	.chip_select_3_or_io_n (chip_select_3_or_io_n),
	.io_select             (io_select),
	.io_level              (io_level),
	.irq_clear             (irq_clear),
	.irq_n                 (irq_n),
	.busy                  (busy)
);
`default_nettype wire

// ==== dv/isb_i2c_master.sv ====
/*
 behavioural i2c master with open-drain pull-low outputs.
 assumes the bench resolves the wires; one bit takes 160 ns.
*/
`timescale 1ns/1ps
`default_nettype none

module isb_i2c_master (
	input  wire logic scl,
	input  wire logic sda,
	output var  logic scl_low,
	output var  logic sda_low
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	task automatic bitx(input logic b, output logic r);
		sda_low = !b;
		#40 scl_low = 1'b0;
		wait (scl === 1'b1);
		#40 r = sda;
		#40 scl_low = 1'b1;
		#40;
	endtask

	task automatic start;
		sda_low = 1'b1;
		#80 scl_low = 1'b1;
		#40;
	endtask

	task automatic stop;
		sda_low = 1'b1;
		#40 scl_low = 1'b0;
		wait (scl === 1'b1);
		#80 sda_low = 1'b0;
		#80;
	endtask

	// one byte msb first, then the ninth bit left to the receiver
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(b[i], r);
		end
		bitx(1'b1, r);
		ack = !r;
	endtask

	task automatic rbyte(output logic [7:0] b, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			b[i] = r;
		end
		bitx(last, r);
	endtask
endmodule
`default_nettype wire

// ==== dv/tb_isb_front_end.sv ====
/*
 self-checking bench for the i2c slave buffer front end.
 assumes miso loops back mosi inverted, so captured bytes read back inverted.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_isb_front_end;
	localparam logic [6:0] ADDR = {4'h5, 3'b101};
	logic core_clk, sys_rst, clk_en, irq_clear, miso;
	logic scl_oe, scl_out, sda_oe, sda_out, mosi, sclk, irq_n, busy;
	logic m_scl_low, m_sda_low, s0, s1, s2, s3;
	logic seen_clr, sclk_q;
	logic [2:0] strap;
	logic [3:0] io_select, io_level, seen, ak;
	logic [7:0] r0, r1, mosi_sr;
	int num_errors = 0;
	int samples_checked = 0;
	int n;
	wire scl_bus = (scl_oe ? scl_out : 1'b1) & ~m_scl_low;
	wire sda_bus = (sda_oe ? sda_out : 1'b1) & ~m_sda_low;

	assign miso = ~mosi;

	isb_i2c_master u_mst (.scl(scl_bus), .sda(sda_bus), .scl_low(m_scl_low),
		.sda_low(m_sda_low));

	isb_front_end u_dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.scl_in(scl_bus), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
		.addr_strap_bit2(strap[2]), .miso(miso), .mosi(mosi),
		.serial_clock_out(sclk), .chip_select_0_or_io_n(s0),
		.chip_select_1_or_io_n(s1), .chip_select_2_or_io_n(s2),
		.chip_select_3_or_io_n(s3), .io_select(io_select), .io_level(io_level),
		.irq_clear(irq_clear), .irq_n(irq_n), .busy(busy));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// mosi is caught on rising serial clock edges while any select is low
	always @(posedge core_clk) begin
		sclk_q <= sclk;
		if (sclk && !sclk_q && !(&{s3, s2, s1, s0}))
			mosi_sr <= {mosi_sr[6:0], mosi};
		if (seen_clr)
			seen <= 4'h0;
		else if (io_select == 4'h0)
			seen <= seen | ~{s3, s2, s1, s0};
	end

	task automatic chk(input string name, input logic [7:0] seen_v, input logic [7:0] exp);
		samples_checked++;
		if (seen_v !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen_v);
		end
	endtask

	task automatic test_done;
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic ticks(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	task automatic wait_idle;
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			ticks(1);
			n++;
		end
	endtask

	initial begin
		#400_000;
		num_errors++;
		test_done;
	end

	initial begin
		sys_rst = 1'b1; clk_en = 1'b1; irq_clear = 1'b0; strap = 3'b101;
		io_select = 4'h0; io_level = 4'h0; seen_clr = 1'b1;
		ticks(12);
		sys_rst = 1'b0;
		strap = 3'b010; // later strap change must be ignored
		ticks(4);
		u_mst.start; u_mst.wbyte({4'h5, 3'b010, 1'b0}, ak[0]); u_mst.stop;
		chk("ack_new_strap", 8'(ak[0]), 8'h00);
		for (int c = 1; c <= 15; c++) begin
			seen_clr = 1'b1;
			ticks(1);
			seen_clr = 1'b0;
			u_mst.start;
			u_mst.wbyte({ADDR, 1'b0}, ak[3]);
			u_mst.wbyte(8'(c), ak[2]);
			u_mst.wbyte(8'(c), ak[1]);
			u_mst.wbyte(8'h5a, ak[0]);
			u_mst.stop;
			chk("ack_write", 8'(ak), 8'h0f);
			ticks(10);
			chk("busy", 8'(busy), 8'h01);
			if (c == 1) begin
				u_mst.start; u_mst.wbyte({ADDR, 1'b0}, ak[0]); u_mst.stop;
				chk("ack_busy", 8'(ak[0]), 8'h00);
			end
			wait_idle;
			chk("done", 8'(busy), 8'h00);
			chk("mosi_msb", mosi_sr, 8'h5a);
			chk("sel_mask", 8'(seen), 8'(c));
			chk("irq", 8'(irq_n), 8'h00);
			irq_clear = 1'b1; ticks(1); irq_clear = 1'b0; ticks(1);
			chk("irq_clr", 8'(irq_n), 8'h01);
		end
		// two reads: captured reply comes back and survives the first read
		repeat (2) begin
			u_mst.start; u_mst.wbyte({ADDR, 1'b1}, ak[0]);
			u_mst.rbyte(r0, 1'b0); u_mst.rbyte(r1, 1'b1); u_mst.stop;
			chk("ack_read", 8'(ak[0]), 8'h01);
			chk("rd0", r0, ~8'h0f);
			chk("rd1", r1, ~8'h5a);
		end
		u_mst.start; u_mst.wbyte({ADDR, 1'b0}, ak[2]);
		u_mst.wbyte(8'hf0, ak[1]); u_mst.wbyte(8'h2d, ak[0]); u_mst.stop;
		ticks(20);
		chk("cfg_idle", 8'(sclk), 8'h01);
		chk("cfg_busy", 8'(busy), 8'h00);
		// lsb first, cpol and cpha set, second rate: one byte out and back
		u_mst.start;
		u_mst.wbyte({ADDR, 1'b0}, ak[2]);
		u_mst.wbyte(8'h01, ak[1]);
		u_mst.wbyte(8'h35, ak[0]);
		u_mst.stop;
		chk("ack_lsb", 8'(ak[2:0]), 8'h07);
		wait_idle;
		chk("done_lsb", 8'(busy), 8'h00);
		chk("mosi_lsb", mosi_sr, 8'hac);
		u_mst.start;
		u_mst.wbyte({ADDR, 1'b1}, ak[0]);
		u_mst.rbyte(r0, 1'b1);
		u_mst.stop;
		chk("rd_cpha1", r0, ~8'h35);
		io_select = 4'h1; ticks(3);
		chk("pin_low", 8'(s0), 8'h00);
		io_level = 4'h1; ticks(3);
		chk("pin_high", 8'(s0), 8'h01);
		io_select = 4'h0;
		ticks(3);
		test_done;
	end
endmodule
`default_nettype wire

// ==== rtl/isb_front_end.v ====
/*
 i2c slave front end of an i2c to serial bridge with a 200 byte buffer.
 assumes open-drain pads resolved outside; scl, sda and miso are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "isb_map.vh"

module isb_front_end #(
	parameter [3:0] FIXED_ADDR = 4'h5 // arbitrary upper address part
) (
	input  wire       core_clk,
	input  wire       sys_rst,
	input  wire       clk_en,
	input  wire       scl_in,
	output reg        scl_out,
	output reg        scl_oe,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	input  wire       addr_strap_bit0,
	input  wire       addr_strap_bit1,
	input  wire       addr_strap_bit2,
	input  wire       miso,
	output wire       mosi,
	output wire       serial_clock_out,
	output reg        chip_select_0_or_io_n,
	output reg        chip_select_1_or_io_n,
	output reg        chip_select_2_or_io_n,
	output reg        chip_select_3_or_io_n,
	input  wire [3:0] io_select,
	input  wire [3:0] io_level,
	input  wire       irq_clear,
	output reg        irq_n,
	output reg        busy
);
	localparam [6:0] S_IDLE  = 7'h01;
	localparam [6:0] S_ADDR  = 7'h02;
	localparam [6:0] S_RX    = 7'h04;
	localparam [6:0] S_ACK   = 7'h08;
	localparam [6:0] S_LOAD  = 7'h10;
	localparam [6:0] S_TX    = 7'h20;
	localparam [6:0] S_TXACK = 7'h40;

	reg  [2:0] scl_sync_reg;
	reg  [2:0] sda_sync_reg;
	reg  [2:0] strap_meta_reg;
	reg  [2:0] strap_sync_reg;
	reg  [1:0] miso_sync_reg;
	reg  [2:0] strap_reg;
	reg  [6:0] state_reg;
	reg  [7:0] shift_reg;
	reg  [3:0] bit_cnt_reg;
	reg        rw_reg;
	reg        active_wr_reg;
	reg        got_fn_reg;
	reg  [7:0] fn_reg;
	reg  [7:0] wr_idx_reg;
	reg  [7:0] rd_idx_reg;
	reg  [7:0] cfg_reg;
	reg        spi_start_reg;
	reg  [7:0] buf_mem [0:`ISB_RD_LAST];
	reg  [3:0] cs_pin;
	wire [3:0] spi_cs_n;
	wire [7:0] spi_idx;
	wire [7:0] spi_rx_idx;
	wire [7:0] spi_rx_byte;
	wire       spi_rx_we;
	wire       spi_done;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_seen;
	wire       stop_seen;
	wire       addr_match;
	wire       byte_done;
	wire [7:0] rd_byte;
	wire       i2c_store;

	// edge logic reads only the second and third stages
	assign scl_rise   = scl_sync_reg[1] & ~scl_sync_reg[2];
	assign scl_fall   = ~scl_sync_reg[1] & scl_sync_reg[2];
	assign start_seen = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
	assign stop_seen  = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];
	assign byte_done  = scl_fall & (bit_cnt_reg == `ISB_BITS_PER_BYTE);
	assign addr_match = (shift_reg[7:1] == {FIXED_ADDR, strap_reg}) & ~busy;
	assign rd_byte    = buf_mem[rd_idx_reg];
	assign i2c_store  = (state_reg == S_RX) & byte_done & got_fn_reg
	                  & (wr_idx_reg < `ISB_BUF_DEPTH);

	always @(posedge core_clk) begin
		if (clk_en) begin
			scl_sync_reg   <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg   <= {sda_sync_reg[1:0], sda_in};
			strap_meta_reg <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
			strap_sync_reg <= strap_meta_reg;
			miso_sync_reg  <= {miso_sync_reg[0], miso};
		end
	end

	// buffer holds data only, so it carries no reset
	always @(posedge core_clk) begin
		if (clk_en) begin
			if (i2c_store)
				buf_mem[wr_idx_reg] <= shift_reg;
			else if (spi_rx_we)
				buf_mem[spi_rx_idx] <= spi_rx_byte;
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			strap_reg     <= strap_sync_reg;
			state_reg     <= S_IDLE;
			shift_reg     <= 8'h00;
			bit_cnt_reg   <= 4'h0;
			rw_reg        <= 1'b0;
			active_wr_reg <= 1'b0;
			got_fn_reg    <= 1'b0;
			fn_reg        <= `ISB_FN_NONE;
			wr_idx_reg    <= 8'h00;
			rd_idx_reg    <= 8'h00;
			cfg_reg       <= `ISB_CFG_RESET;
			spi_start_reg <= 1'b0;
			busy          <= 1'b0;
			irq_n         <= 1'b1;
			scl_out       <= 1'b0;
			scl_oe        <= 1'b0;
			sda_out       <= 1'b0;
			sda_oe        <= 1'b0;
		end else if (clk_en) begin
			spi_start_reg <= 1'b0;
			if (spi_done) begin
				busy  <= 1'b0;
				irq_n <= 1'b0;
			end else if (irq_clear) begin
				irq_n <= 1'b1;
			end
			if (start_seen) begin
				state_reg   <= S_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe      <= 1'b0;
				scl_oe      <= 1'b0;
			end else if (stop_seen) begin
				state_reg     <= S_IDLE;
				sda_oe        <= 1'b0;
				scl_oe        <= 1'b0;
				active_wr_reg <= 1'b0;
				if (active_wr_reg & got_fn_reg) begin
					if (fn_reg != `ISB_FN_NONE && fn_reg <= `ISB_FN_SPI_MAX) begin
						busy          <= 1'b1;
						spi_start_reg <= 1'b1;
					end else if (fn_reg == `ISB_FN_CONFIG && wr_idx_reg != 8'h00) begin
						cfg_reg <= buf_mem[0];
					end
				end
			end else begin
				case (state_reg)
				S_ADDR, S_RX: begin
					if (scl_rise) begin
						shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_done) begin
						bit_cnt_reg <= 4'h0;
						state_reg   <= S_ACK;
						if (state_reg == S_ADDR) begin
							if (addr_match) begin
								sda_oe        <= 1'b1;
								rw_reg        <= shift_reg[0];
								active_wr_reg <= ~shift_reg[0];
								rd_idx_reg    <= 8'h00;
								if (!shift_reg[0]) begin
									got_fn_reg <= 1'b0;
									wr_idx_reg <= 8'h00;
								end
							end else begin
								state_reg <= S_IDLE;
							end
						end else if (!got_fn_reg) begin
							fn_reg     <= shift_reg;
							got_fn_reg <= 1'b1;
							sda_oe     <= 1'b1;
						end else if (i2c_store) begin
							wr_idx_reg <= wr_idx_reg + 8'h01;
							sda_oe     <= 1'b1;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						if (rw_reg) begin
							state_reg <= S_LOAD;
							scl_oe    <= 1'b1;
						end else begin
							state_reg <= S_RX;
						end
					end
				end
				S_LOAD: begin
					// one cycle of stretch covers the buffer fetch
					shift_reg   <= {rd_byte[6:0], 1'b0};
					sda_oe      <= ~rd_byte[7];
					scl_oe      <= 1'b0;
					bit_cnt_reg <= 4'h0;
					state_reg   <= S_TX;
					if (rd_idx_reg != `ISB_RD_LAST)
						rd_idx_reg <= rd_idx_reg + 8'h01;
				end
				S_TX: begin
					if (scl_rise) begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_done) begin
						sda_oe    <= 1'b0;
						state_reg <= S_TXACK;
					end else if (scl_fall) begin
						sda_oe    <= ~shift_reg[7];
						shift_reg <= {shift_reg[6:0], 1'b0};
					end
				end
				S_TXACK: begin
					if (scl_rise & sda_sync_reg[1]) begin
						state_reg <= S_IDLE;
					end else if (scl_fall) begin
						state_reg <= S_LOAD;
						scl_oe    <= 1'b1;
					end
				end
				S_IDLE: begin
					sda_oe <= 1'b0;
					scl_oe <= 1'b0;
				end
				default: begin
					state_reg <= S_IDLE;
					sda_oe    <= 1'b0;
					scl_oe    <= 1'b0;
				end
				endcase
			end
		end
	end

	isb_spi_engine u_spi (
		.clk       (core_clk),
		.rst       (sys_rst),
		.ce        (clk_en),
		.start     (spi_start_reg),
		.len       (wr_idx_reg),
		.cs_mask   (fn_reg[`ISB_CS_MASK_HI:`ISB_CS_MASK_LO]),
		.lsb_first (cfg_reg[`ISB_CFG_ORDER]),
		.mode      (cfg_reg[`ISB_CFG_MODE_HI:`ISB_CFG_MODE_LO]),
		.rate      (cfg_reg[`ISB_CFG_RATE_HI:`ISB_CFG_RATE_LO]),
		.tx_byte   (buf_mem[spi_idx]),
		.miso      (miso_sync_reg[1]),
		.byte_idx  (spi_idx),
		.rx_idx    (spi_rx_idx),
		.rx_byte   (spi_rx_byte),
		.rx_we     (spi_rx_we),
		.done      (spi_done),
		.sclk      (serial_clock_out),
		.mosi      (mosi),
		.cs_n      (spi_cs_n)
	);

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_pin
			always @(posedge core_clk) begin
				if (sys_rst)
					cs_pin[g] <= 1'b1;
				else if (clk_en)
					cs_pin[g] <= io_select[g] ? io_level[g] : spi_cs_n[g];
			end
		end
	endgenerate

	always @* begin
		chip_select_0_or_io_n = cs_pin[0];
		chip_select_1_or_io_n = cs_pin[1];
		chip_select_2_or_io_n = cs_pin[2];
		chip_select_3_or_io_n = cs_pin[3];
	end
endmodule

`default_nettype wire

// ==== rtl/isb_map.vh ====
/*
 constants for the i2c slave buffer front end and its serial master engine.
 assumes a 125 mhz core clock; included by bare name from the rtl files.
*/
`ifndef ISB_MAP_VH
`define ISB_MAP_VH

// i2c slave buffer
`define ISB_BUF_DEPTH     8'd200
`define ISB_RD_LAST       8'd199
`define ISB_BITS_PER_BYTE 4'd8
`define ISB_FN_CONFIG     8'hf0
`define ISB_FN_SPI_MAX    8'h0f
`define ISB_FN_NONE       8'h00
`define ISB_CS_MASK_LO    0
`define ISB_CS_MASK_HI    3

// configuration byte fields and reset value
`define ISB_CFG_ORDER     5
`define ISB_CFG_MODE_HI   3
`define ISB_CFG_MODE_LO   2
`define ISB_CFG_RATE_HI   1
`define ISB_CFG_RATE_LO   0
`define ISB_CFG_RESET     8'h00

// serial link rates, in khz, against the core clock
`define ISB_CLK_KHZ       125000
`define ISB_SPI_KHZ0      1843
`define ISB_SPI_KHZ1      461
`define ISB_SPI_KHZ2      115
`define ISB_SPI_KHZ3      58
`define ISB_HALF_CYC(k)   ((`ISB_CLK_KHZ + 2 * (k) - 1) / (2 * (k)))
`define ISB_HALVES_LAST   4'hf

`endif

// ==== rtl/isb_spi_engine.v ====
/*
 serial master engine: shifts a buffered payload out and captures the reply.
 assumes the buffer read data for byte_idx is presented combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
`include "isb_map.vh"

module isb_spi_engine (
	input  wire       clk,
	input  wire       rst,
	input  wire       ce,
	input  wire       start,
	input  wire [7:0] len,
	input  wire [3:0] cs_mask,
	input  wire       lsb_first,
	input  wire [1:0] mode,
	input  wire [1:0] rate,
	input  wire [7:0] tx_byte,
	input  wire       miso,
	output reg  [7:0] byte_idx,
	output reg  [7:0] rx_idx,
	output reg  [7:0] rx_byte,
	output reg        rx_we,
	output reg        done,
	output reg        sclk,
	output reg        mosi,
	output reg  [3:0] cs_n
);
	localparam integer HALF0_CYC = `ISB_HALF_CYC(`ISB_SPI_KHZ0);
	localparam integer HALF1_CYC = `ISB_HALF_CYC(`ISB_SPI_KHZ1);
	localparam integer HALF2_CYC = `ISB_HALF_CYC(`ISB_SPI_KHZ2);
	localparam integer HALF3_CYC = `ISB_HALF_CYC(`ISB_SPI_KHZ3);
	// counts fit in eleven bits, the cut is on purpose
	localparam [10:0] HALF0 = HALF0_CYC[10:0];
	localparam [10:0] HALF1 = HALF1_CYC[10:0];
	localparam [10:0] HALF2 = HALF2_CYC[10:0];
	localparam [10:0] HALF3 = HALF3_CYC[10:0];

	reg        run_reg;
	reg        load_reg;
	reg  [3:0] half_reg;
	reg [10:0] div_reg;
	reg  [7:0] sr_reg;
	reg  [7:0] rx_sr_reg;
	reg [10:0] half_lim;
	wire [7:0] rx_full;
	wire [7:0] tx_ord;

	function [7:0] order;
		input [7:0] b;
		input       lsb;
		integer     i;
		begin
			for (i = 0; i < 8; i = i + 1)
				order[i] = lsb ? b[7 - i] : b[i];
		end
	endfunction

	always @* begin
		case (rate)
		2'b00: half_lim = HALF0;
		2'b01: half_lim = HALF1;
		2'b10: half_lim = HALF2;
		default: half_lim = HALF3;
		endcase
	end

	// with cpha set the last sample lands on the final trailing edge
	assign rx_full = mode[0] ? {rx_sr_reg[6:0], miso} : rx_sr_reg;
	assign tx_ord  = order(tx_byte, lsb_first);

	always @(posedge clk) begin
		if (rst) begin
			run_reg   <= 1'b0;
			load_reg  <= 1'b0;
			half_reg  <= 4'h0;
			div_reg   <= 11'h000;
			sr_reg    <= 8'h00;
			rx_sr_reg <= 8'h00;
			byte_idx  <= 8'h00;
			rx_idx    <= 8'h00;
			rx_byte   <= 8'h00;
			rx_we     <= 1'b0;
			done      <= 1'b0;
			sclk      <= 1'b0;
			mosi      <= 1'b0;
			cs_n      <= 4'hf;
		end else if (ce) begin
			rx_we <= 1'b0;
			done  <= 1'b0;
			if (!run_reg) begin
				sclk <= mode[1];
				if (start) begin
					byte_idx <= 8'h00;
					if (len == 8'h00) begin
						done <= 1'b1;
					end else begin
						run_reg  <= 1'b1;
						load_reg <= 1'b1;
						half_reg <= 4'h0;
						div_reg  <= 11'h000;
						cs_n     <= ~cs_mask;
					end
				end
			end else if (load_reg) begin
				load_reg <= 1'b0;
				div_reg  <= div_reg + 11'h001;
				if (!mode[0]) begin
					mosi   <= tx_ord[7];
					sr_reg <= {tx_ord[6:0], 1'b0};
				end else begin
					sr_reg <= tx_ord;
				end
			end else if (div_reg == half_lim - 11'h001) begin
				div_reg  <= 11'h000;
				sclk     <= ~sclk;
				half_reg <= half_reg + 4'h1;
				if (half_reg[0] == mode[0]) begin
					rx_sr_reg <= {rx_sr_reg[6:0], miso};
				end else begin
					mosi   <= sr_reg[7];
					sr_reg <= {sr_reg[6:0], 1'b0};
				end
				if (half_reg == `ISB_HALVES_LAST) begin
					rx_idx  <= byte_idx;
					rx_byte <= order(rx_full, lsb_first);
					rx_we   <= 1'b1;
					if (byte_idx + 8'h01 == len) begin
						run_reg <= 1'b0;
						cs_n    <= 4'hf;
						done    <= 1'b1;
					end else begin
						byte_idx <= byte_idx + 8'h01;
						load_reg <= 1'b1;
					end
				end
			end else begin
				div_reg <= div_reg + 11'h001;
			end
		end
	end
endmodule

`default_nettype wire
